// file: rtl/scp_device.sv
// Purpose: device end of the serial control port with its four registers
// Assumes: link clock pulses only during frames plus one trailing pulse
// Notes:   link side on serial clock, user side on CLOCK, toggle crossings
`timescale 1ns/1ps

module scp_device
   import scp_pkg::*;
#(
   // identity words, values arbitrary
   parameter logic [15:0] ID_LOW  = 16'h0001,
   parameter logic [15:0] ID_HIGH = 16'h0000
)
(
   // system
   input  wire logic       CLOCK,
   input  wire logic       RST,
   // receiver measurement
   input  wire logic       PACKET_DETECT,
   input  wire logic [6:0] POWER_LEVEL,
   input  wire logic       SLEEP_MODE,
   // control fields
   output logic [6:0]      SIGNAL_STRENGTH_CODE,
   output logic            SPUR_CANCEL_OFF,
   output logic            REF_HALVING_OFF,
   output logic [1:0]      SLEEP_CLOCK_SELECT,
   output logic [2:0]      TX_ATTEN_CODE,
   output logic            SLOW_GAIN_LOOP_OFF,
   output logic            SLEEP_CLK,
   // link
   scp_link_if.device      lk
);

   function automatic logic [15:0] read_word(input logic [4:0] a, input logic [6:0] ss);
      logic [15:0] w;
      w = 16'h0000;
      if (a == REG_SIGNAL_STRENGTH)
         w = {9'h000, ss};
      else if (a == REG_ID_LOW)
         w = ID_LOW;
      else if (a == REG_ID_HIGH)
         w = ID_HIGH;
      return w;
   endfunction

   logic [4:0]  cnt_q;
   logic [24:0] shift_in_q;
   logic        drive_q;
   logic [15:0] rd_shift_q;
   logic        arm_q;
   logic [15:0] reg4_q;
   logic        w_tog_q;
   logic        ss_tog_s1_q;
   logic        ss_tog_s2_q;
   logic        ss_seen_q;
   logic [6:0]  ss_link_q;
   logic        hdr_match_w;
   logic        hdr_read_w;
   logic        full_write_w;

   // header sits in the low nine bits when the count reaches nine
   assign hdr_match_w = shift_in_q[8:6] == DEV_ADDR;
   assign hdr_read_w  = shift_in_q[5];
   // only a matching write to register 4 commits
   assign full_write_w = (cnt_q == 5'(FRAME_BITS)) && (shift_in_q[24:22] == DEV_ADDR)
                         && !shift_in_q[21] && (shift_in_q[20:16] == REG_IF_CONTROL_2);

   // sample on rising edge, msb first
   always_ff @(posedge lk.serial_port_clock or posedge RST)
   begin
      if (RST)
      begin
         cnt_q      <= 5'h0;
         shift_in_q <= 25'h000_0000;
         arm_q      <= 1'b0;
      end
      else if (lk.serial_latch_enable_n)
      begin
         cnt_q <= 5'h0;
         arm_q <= full_write_w;
      end
      else
      begin
         arm_q      <= 1'b0;
         // always shifts, so a frame cut before its latch pulse is overwritten
         // limitation: count saturates, a read then needs a latch pulse first
         shift_in_q <= {shift_in_q[23:0], lk.serial_port_data_line};
         if (cnt_q < 5'(FRAME_BITS))
            cnt_q <= cnt_q + 5'h1;
      end
   end

   // drive read data from the tenth rising edge
   always_ff @(posedge lk.serial_port_clock or posedge RST)
   begin
      if (RST)
      begin
         drive_q    <= 1'b0;
         rd_shift_q <= 16'h0000;
      end
      else if (lk.serial_latch_enable_n)
         drive_q <= 1'b0;
      else if (cnt_q == 5'(HDR_BITS) && hdr_match_w && hdr_read_w)
      begin
         // unimplemented or write-only addresses return zero
         drive_q    <= 1'b1;
         rd_shift_q <= read_word(shift_in_q[4:0], ss_link_q);
      end
      else if (drive_q)
         rd_shift_q <= {rd_shift_q[14:0], 1'b0};
   end

   // release at once when latch enable rises
   assign lk.dev_data_oe_n = !(drive_q && !lk.serial_latch_enable_n);
   assign lk.dev_data_out  = rd_shift_q[15];

   // commit on first falling edge after latch
   always_ff @(negedge lk.serial_port_clock or posedge RST)
   begin
      if (RST)
      begin
         reg4_q  <= IF_CONTROL_2_RESET;
         w_tog_q <= 1'b0;
      end
      else if (arm_q && lk.serial_latch_enable_n)
      begin
         reg4_q  <= shift_in_q[15:0];
         w_tog_q <= ~w_tog_q;
      end
   end

   // strength word crossing into link domain
   logic [6:0] ss_hold_q;
   logic       ss_tog_q;

   // loaded only before read data starts, so a read never tears
   always_ff @(posedge lk.serial_port_clock or posedge RST)
   begin
      if (RST)
      begin
         ss_tog_s1_q <= 1'b0;
         ss_tog_s2_q <= 1'b0;
         ss_seen_q   <= 1'b0;
         ss_link_q   <= 7'h00;
      end
      else
      begin
         ss_tog_s1_q <= ss_tog_q;
         ss_tog_s2_q <= ss_tog_s1_q;
         if (ss_tog_s2_q != ss_seen_q && cnt_q < 5'(HDR_BITS))
         begin
            ss_seen_q <= ss_tog_s2_q;
            ss_link_q <= ss_hold_q;
         end
      end
   end

   // average dB code over the measuring window
   logic       meas_q;
   logic [7:0] meas_cnt_q;
   logic [14:0] sum_q;
   logic [14:0] sum_w;

   assign sum_w = sum_q + 15'(POWER_LEVEL);

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         meas_q     <= 1'b0;
         meas_cnt_q <= 8'h00;
         sum_q      <= 15'h0000;
         ss_hold_q  <= 7'h00;
         ss_tog_q   <= 1'b0;
      end
      else if (!meas_q)
      begin
         meas_q     <= PACKET_DETECT;
         meas_cnt_q <= 8'h00;
         sum_q      <= 15'h0000;
      end
      else if (meas_cnt_q == 8'(MEAS_CYCLES - 1))
      begin
         meas_q    <= 1'b0;
         ss_hold_q <= 7'(sum_w / 15'(MEAS_CYCLES));
         ss_tog_q  <= ~ss_tog_q;
      end
      else
      begin
         meas_cnt_q <= meas_cnt_q + 8'h01;
         sum_q      <= sum_w;
      end
   end

   // register 4 crossing into CLOCK domain
   logic        w_s1_q;
   logic        w_s2_q;
   logic        w_seen_q;
   logic [15:0] ctl_q;

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         w_s1_q   <= 1'b0;
         w_s2_q   <= 1'b0;
         w_seen_q <= 1'b0;
         ctl_q    <= IF_CONTROL_2_RESET;
      end
      else
      begin
         w_s1_q <= w_tog_q;
         w_s2_q <= w_s1_q;
         if (w_s2_q != w_seen_q)
         begin
            w_seen_q <= w_s2_q;
            ctl_q    <= reg4_q;
         end
      end
   end

   assign SPUR_CANCEL_OFF      = ctl_q[SPUR_OFF_BIT];
   assign REF_HALVING_OFF      = ctl_q[REF_HALF_OFF_BIT];
   assign SLEEP_CLOCK_SELECT   = ctl_q[SLEEP_SEL_LSB +: 2];
   assign TX_ATTEN_CODE        = ctl_q[ATTEN_LSB +: ATTEN_BITS];
   assign SLOW_GAIN_LOOP_OFF   = ctl_q[SLOW_AGC_OFF_BIT];
   assign SIGNAL_STRENGTH_CODE = ss_hold_q;

   // sleep clock, held low outside sleep
   logic [11:0] sc_cnt_q;
   logic        sc_q;
   logic        sc_en_w;
   logic [11:0] sc_half_w;

   assign sc_en_w   = SLEEP_MODE && (SLEEP_CLOCK_SELECT != 2'h3);
   assign sc_half_w = SLEEP_CLOCK_SELECT[1] ? 12'(SLOW_HALF_CYCLES) : 12'(FAST_HALF_CYCLES);

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         sc_cnt_q <= 12'h000;
         sc_q     <= 1'b0;
      end
      else if (!sc_en_w)
      begin
         sc_cnt_q <= 12'h000;
         sc_q     <= 1'b0;
      end
      else if (sc_cnt_q >= sc_half_w - 12'h001)
      begin
         sc_cnt_q <= 12'h000;
         sc_q     <= ~sc_q;
      end
      else
         sc_cnt_q <= sc_cnt_q + 12'h001;
   end

   assign SLEEP_CLK = sc_q;

endmodule

// file: shared/scp_pkg.sv
// Purpose: shared constants of the serial control port, both ends
// Assumes: 25 MHz system clock, 16-bit registers, 25-bit packets
// Notes:   offsets are 5-bit register addresses carried in the packet
package scp_pkg;

   // packet layout
   localparam logic [2:0] DEV_ADDR        = 3'h5;
   localparam int         DEV_ADDR_BITS   = 3;
   localparam int         REG_ADDR_BITS   = 5;
   localparam int         HDR_BITS        = DEV_ADDR_BITS + 1 + REG_ADDR_BITS;
   localparam int         DATA_BITS       = 16;
   localparam int         FRAME_BITS      = HDR_BITS + DATA_BITS;

   // register addresses
   localparam logic [4:0] REG_SIGNAL_STRENGTH = 5'h03;
   localparam logic [4:0] REG_IF_CONTROL_2    = 5'h04;
   localparam logic [4:0] REG_LAST_LOW_BLOCK  = 5'h07;
   localparam logic [4:0] REG_ID_LOW          = 5'h1E;
   localparam logic [4:0] REG_ID_HIGH         = 5'h1F;

   // field positions
   localparam int SS_BITS          = 7;
   localparam int SPUR_OFF_BIT     = 11;
   localparam int REF_HALF_OFF_BIT = 10;
   localparam int SLEEP_SEL_LSB    = 8;
   localparam int ATTEN_LSB        = 5;
   localparam int ATTEN_BITS       = 3;
   localparam int SLOW_AGC_OFF_BIT = 4;

   // reset value of the second IF control register
   localparam logic [15:0] IF_CONTROL_2_RESET = 16'h0400;

   // timing
   localparam int CLOCK_PERIOD_NS = 40;
   localparam int CLOCK_HZ        = 25_000_000;
   localparam int MEAS_TIME_NS    = 10_000;
   localparam int MEAS_CYCLES     = (MEAS_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int SLEEP_FAST_HZ   = 32_000;
   localparam int SLEEP_SLOW_HZ   = 3_200;
   localparam int FAST_HALF_CYCLES = CLOCK_HZ / (2 * SLEEP_FAST_HZ);
   localparam int SLOW_HALF_CYCLES = CLOCK_HZ / (2 * SLEEP_SLOW_HZ);
   localparam int SCLK_HALF_CYCLES = 4;

endpackage

// file: shared/scp_link_if.sv
// Purpose: three-wire serial control link between controller and device
// Assumes: data line has a pull-up when neither end drives it
// Notes:   enables are active low; wire level resolved here
`timescale 1ns/1ps
interface scp_link_if;
   logic serial_port_clock;
   logic serial_latch_enable_n;
   logic host_data_out;
   logic host_data_oe_n;
   logic dev_data_out;
   logic dev_data_oe_n;
   logic serial_port_data_line;

   // controller wins if both drive; pull-up otherwise
   assign serial_port_data_line = !host_data_oe_n ? host_data_out :
                                  !dev_data_oe_n  ? dev_data_out  : 1'b1;

   modport host
   (
      output serial_port_clock,
      output serial_latch_enable_n,
      output host_data_out,
      output host_data_oe_n,
      input  serial_port_data_line
   );

   modport device
   (
      input  serial_port_clock,
      input  serial_latch_enable_n,
      output dev_data_out,
      output dev_data_oe_n,
      input  serial_port_data_line
   );
endinterface

// file: rtl/scp_host.sv
// Purpose: controller end, master of the serial control port
// Assumes: one access at a time from the user side
// Notes:   serial clock is CLOCK divided by 2*SCLK_HALF_CYCLES, idle low
`timescale 1ns/1ps
module scp_host
   import scp_pkg::*;
(
   // system
   input  wire logic        CLOCK,
   input  wire logic        RST,
   // command
   input  wire logic        REQ_VALID,
   output logic             REQ_READY,
   input  wire logic        REQ_READ,
   input  wire logic [4:0]  REQ_REG,
   input  wire logic [15:0] REQ_WDATA,
   // answer
   output logic             DONE,
   output logic [15:0]      RD_DATA,
   // link
   scp_link_if.host         lk
);

   typedef enum logic [1:0] {H_IDLE, H_FRAME, H_TAIL} scp_host_e;

   scp_host_e   state_q;
   logic [2:0]  phase_q;
   logic        sclk_q;
   logic [4:0]  bit_q;
   logic [24:0] tx_q;
   logic        rd_q;
   logic        le_n_q;
   logic        oe_n_q;
   logic        done_q;
   logic [15:0] rd_data_q;
   logic        din_s1_q;
   logic        din_s2_q;
   logic        edge_w;
   logic        rise_w;
   logic        fall_w;

   assign edge_w = (state_q != H_IDLE) && (phase_q == 3'(SCLK_HALF_CYCLES - 1));
   assign rise_w = edge_w && !sclk_q;
   assign fall_w = edge_w && sclk_q;

   // data line comes from the link domain
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         din_s1_q <= 1'b1;
         din_s2_q <= 1'b1;
      end
      else
      begin
         din_s1_q <= lk.serial_port_data_line;
         din_s2_q <= din_s1_q;
      end
   end

   // clock divider
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         phase_q <= 3'h0;
         sclk_q  <= 1'b0;
      end
      else if (state_q == H_IDLE)
      begin
         phase_q <= 3'h0;
         sclk_q  <= 1'b0;
      end
      else if (edge_w)
      begin
         phase_q <= 3'h0;
         sclk_q  <= ~sclk_q;
      end
      else
         phase_q <= phase_q + 3'h1;
   end

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         state_q   <= H_IDLE;
         bit_q     <= 5'h0;
         tx_q      <= 25'h000_0000;
         rd_q      <= 1'b0;
         le_n_q    <= 1'b1;
         oe_n_q    <= 1'b0;
         done_q    <= 1'b0;
         rd_data_q <= 16'h0000;
      end
      else
      begin
         done_q <= 1'b0;
         unique case (state_q)
            H_IDLE:
            begin
               if (REQ_VALID)
               begin
                  tx_q    <= {DEV_ADDR, REQ_READ, REQ_REG, REQ_WDATA};
                  rd_q    <= REQ_READ;
                  bit_q   <= 5'h0;
                  le_n_q  <= 1'b0;
                  state_q <= H_FRAME;
               end
            end
            H_FRAME:
            begin
               if (rise_w)
                  bit_q <= bit_q + 5'h1;
               if (fall_w)
               begin
                  // next bit presented on falling edge
                  tx_q <= {tx_q[23:0], 1'b0};
                  // release line half a cycle after header
                  if (rd_q && bit_q == 5'(HDR_BITS))
                     oe_n_q <= 1'b1;
                  if (rd_q && bit_q > 5'(HDR_BITS))
                     rd_data_q <= {rd_data_q[14:0], din_s2_q};
                  // latch enable high after last bit
                  if (bit_q == 5'(FRAME_BITS))
                  begin
                     le_n_q  <= 1'b1;
                     state_q <= H_TAIL;
                  end
               end
            end
            H_TAIL:
            begin
               // resume driving on the extra pulse's fall
               if (fall_w)
               begin
                  oe_n_q  <= 1'b0;
                  done_q  <= 1'b1;
                  state_q <= H_IDLE;
               end
            end
         endcase
      end
   end

   assign REQ_READY                = (state_q == H_IDLE);
   assign DONE                     = done_q;
   assign RD_DATA                  = rd_data_q;
   assign lk.serial_port_clock     = sclk_q;
   assign lk.serial_latch_enable_n = le_n_q;
   assign lk.host_data_out         = tx_q[24];
   assign lk.host_data_oe_n        = oe_n_q;

endmodule

// file: verification/scp_link_assertions.sv
// Purpose: link checks between controller end and device end
// Assumes: link signals sampled on the system clock
// Notes:   counter tracks rising serial edges inside a frame
`timescale 1ns/1ps
module scp_link_assertions
   import scp_pkg::*;
(
   // system
   input wire logic CLOCK,
   input wire logic RST,
   // link
   input wire logic serial_port_clock,
   input wire logic serial_latch_enable_n,
   input wire logic host_data_out,
   input wire logic host_data_oe_n,
   input wire logic dev_data_out,
   input wire logic dev_data_oe_n
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);

   logic [4:0] rise_cnt_q;

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         rise_cnt_q <= 5'h0;
      else if ($fell(serial_latch_enable_n))
         rise_cnt_q <= 5'h0;
      else if ($rose(serial_port_clock) && !serial_latch_enable_n)
         rise_cnt_q <= rise_cnt_q + 5'h1;
   end

   property p_dev_quiet;
      serial_latch_enable_n |-> dev_data_oe_n;
   endproperty
   a_dev_quiet: assert property (p_dev_quiet)
      else $error("device drives line outside frame");

   property p_no_clash;
      !(!host_data_oe_n && !dev_data_oe_n);
   endproperty
   a_no_clash: assert property (p_no_clash)
      else $error("both ends drive data line");

   property p_dev_on_rise;
      !dev_data_oe_n && $changed(dev_data_out) |-> $rose(serial_port_clock);
   endproperty
   a_dev_on_rise: assert property (p_dev_on_rise)
      else $error("device data moved off rising edge");

   property p_host_on_fall;
      !serial_latch_enable_n && !host_data_oe_n && $changed(host_data_out)
         |-> $fell(serial_port_clock) || $fell(serial_latch_enable_n);
   endproperty
   a_host_on_fall: assert property (p_host_on_fall)
      else $error("host data moved off falling edge");

   property p_sclk_high;
      $rose(serial_port_clock) |-> serial_port_clock[*4] ##1 !serial_port_clock;
   endproperty
   a_sclk_high: assert property (p_sclk_high)
      else $error("serial clock high time wrong");

   property p_frame_len;
      $rose(serial_latch_enable_n) |-> rise_cnt_q == 5'(FRAME_BITS);
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("frame bit count wrong");

   property p_turnaround;
      $rose(host_data_oe_n) |-> $fell(serial_port_clock) && !serial_latch_enable_n
         && rise_cnt_q == 5'(HDR_BITS);
   endproperty
   a_turnaround: assert property (p_turnaround)
      else $error("host release not after header");

   property p_dev_start;
      $fell(dev_data_oe_n) |-> $rose(serial_port_clock) && rise_cnt_q == 5'(HDR_BITS);
   endproperty
   a_dev_start: assert property (p_dev_start)
      else $error("device drive start wrong");

   property p_host_resume;
      $fell(host_data_oe_n) |-> $fell(serial_port_clock) && serial_latch_enable_n;
   endproperty
   a_host_resume: assert property (p_host_resume)
      else $error("host resumed off trailing fall");

   property p_resume_soon;
      $rose(serial_latch_enable_n) && host_data_oe_n |-> ##[1:12] !host_data_oe_n;
   endproperty
   a_resume_soon: assert property (p_resume_soon)
      else $error("host did not resume line");
endmodule

// file: verification/tb_top.sv
// Purpose: both ends joined, user sides driven, device fields observed
// Assumes: host makes the link clock; second link driven by the bench
// Notes:   second link breaks framing and addressing on purpose
`timescale 1ns/1ps
module tb_top;
   import scp_pkg::*;
   localparam int          DLY   = 2;
   localparam int          CEIL  = 60000;
   localparam logic [6:0]  LVL   = 7'h35;
   // identity words, values arbitrary
   localparam logic [15:0] ID_LO = 16'h0001;
   localparam logic [15:0] ID_HI = 16'h00A5;

   logic        CLOCK;
   logic        RST;
   logic        REQ_VALID;
   logic        REQ_READY;
   logic        REQ_READ;
   logic [4:0]  REQ_REG;
   logic [15:0] REQ_WDATA;
   logic        DONE;
   logic [15:0] RD_DATA;
   logic        PACKET_DETECT;
   logic [6:0]  POWER_LEVEL;
   logic        SLEEP_MODE;
   logic [6:0]  ss_code;
   logic [7:0]  fa;
   logic [7:0]  fb;
   logic        sleep_a;
   logic [15:0] q;
   logic [15:0] wv [3]   = '{16'h0B70, 16'h0480, 16'hF000};
   logic [4:0]  badr [6] = '{5'h03, 5'h05, 5'h06, 5'h07, 5'h1E, 5'h1F};
   logic [4:0]  radr [6] = '{5'h03, 5'h04, 5'h1E, 5'h1F, 5'h01, 5'h08};
   logic [15:0] rexp [6] = '{{9'h0, LVL}, 16'h0000, ID_LO, ID_HI, 16'h0000, 16'h0000};
   int          errors = 0;
   int          comparisons = 0;
   int          cyc = 0;

   scp_link_if link_a ();
   scp_link_if link_b ();

   scp_host scp_host_inst (.CLOCK(CLOCK), .RST(RST), .REQ_VALID(REQ_VALID),
      .REQ_READY(REQ_READY), .REQ_READ(REQ_READ), .REQ_REG(REQ_REG),
      .REQ_WDATA(REQ_WDATA), .DONE(DONE), .RD_DATA(RD_DATA), .lk(link_a));

   scp_device #(.ID_LOW(ID_LO), .ID_HIGH(ID_HI)) scp_device_inst (.CLOCK(CLOCK),
      .RST(RST), .PACKET_DETECT(PACKET_DETECT), .POWER_LEVEL(POWER_LEVEL),
      .SLEEP_MODE(SLEEP_MODE), .SIGNAL_STRENGTH_CODE(ss_code), .SPUR_CANCEL_OFF(fa[7]),
      .REF_HALVING_OFF(fa[6]), .SLEEP_CLOCK_SELECT(fa[5:4]), .TX_ATTEN_CODE(fa[3:1]),
      .SLOW_GAIN_LOOP_OFF(fa[0]), .SLEEP_CLK(sleep_a), .lk(link_a));

   scp_device scp_device_inst_b (.CLOCK(CLOCK), .RST(RST), .PACKET_DETECT(PACKET_DETECT),
      .POWER_LEVEL(POWER_LEVEL), .SLEEP_MODE(SLEEP_MODE), .SIGNAL_STRENGTH_CODE(),
      .SPUR_CANCEL_OFF(fb[7]), .REF_HALVING_OFF(fb[6]), .SLEEP_CLOCK_SELECT(fb[5:4]),
      .TX_ATTEN_CODE(fb[3:1]), .SLOW_GAIN_LOOP_OFF(fb[0]), .SLEEP_CLK(), .lk(link_b));

   scp_link_assertions scp_link_assertions_inst (.CLOCK(CLOCK), .RST(RST),
      .serial_port_clock(link_a.serial_port_clock),
      .serial_latch_enable_n(link_a.serial_latch_enable_n),
      .host_data_out(link_a.host_data_out), .host_data_oe_n(link_a.host_data_oe_n),
      .dev_data_out(link_a.dev_data_out), .dev_data_oe_n(link_a.dev_data_oe_n));

   initial CLOCK = 1'b0;
   always #20 CLOCK = ~CLOCK;

   task complete_run();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge CLOCK)
   begin
      cyc <= cyc + 1;
      if (cyc == CEIL)
      begin
         errors++;
         complete_run();
      end
   end

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [15:0] fld(input logic [15:0] w);
      return {8'h00, w[SPUR_OFF_BIT], w[REF_HALF_OFF_BIT], w[SLEEP_SEL_LSB +: 2],
              w[ATTEN_LSB +: ATTEN_BITS], w[SLOW_AGC_OFF_BIT]};
   endfunction

   task access(input logic rd, input logic [4:0] adr, input logic [15:0] wd);
      int n;
      n = 0;
      @(posedge CLOCK);
      #DLY;
      REQ_VALID = 1'b1;
      chk("ready", 16'h0001, {15'h0, REQ_READY});
      REQ_READ = rd;
      REQ_REG = adr;
      REQ_WDATA = wd;
      // taken at this edge, host idle
      @(posedge CLOCK);
      #DLY;
      REQ_VALID = 1'b0;
      chk("busy", 16'h0000, {15'h0, REQ_READY});
      while (DONE !== 1'b1 && n < 400)
      begin
         @(posedge CLOCK);
         #DLY;
         n++;
      end
      chk("done", 16'h0001, {15'h0, DONE});
      q = RD_DATA;
      repeat (6) @(posedge CLOCK);
   endtask

   task sleep_half(input int exp);
      int n;
      n = 0;
      while (sleep_a === 1'b1 && n < 9000) begin @(posedge CLOCK); #DLY; n++; end
      while (sleep_a !== 1'b1 && n < 9000) begin @(posedge CLOCK); #DLY; n++; end
      n = 0;
      while (sleep_a === 1'b1 && n < 9000) begin @(posedge CLOCK); #DLY; n++; end
      chk("sleep half", exp[15:0], n[15:0]);
   endtask

   task quiet(input int cycles);
      int hi;
      hi = 0;
      repeat (cycles) begin @(posedge CLOCK); #DLY; if (sleep_a !== 1'b0) hi++; end
      chk("sleep off", 16'h0000, hi[15:0]);
   endtask

   // link clock stands still outside frames, except the trailing pulse when trail is set
   task raw_wr(input logic [2:0] dv, input logic [15:0] wd, input logic trail);
      logic [24:0] bits;
      bits = {dv, 1'b0, REG_IF_CONTROL_2, wd};
      link_b.serial_latch_enable_n = 1'b0;
      for (int i = FRAME_BITS - 1; i >= 0; i--)
      begin
         link_b.host_data_out = bits[i];
         #24 link_b.serial_port_clock = 1'b1;
         #24 link_b.serial_port_clock = 1'b0;
      end
      link_b.serial_latch_enable_n = 1'b1;
      if (trail)
      begin
         #24 link_b.serial_port_clock = 1'b1;
         #24 link_b.serial_port_clock = 1'b0;
      end
      repeat (6) @(posedge CLOCK);
   endtask

   initial
   begin
      RST = 1'b1;
      REQ_VALID = 1'b0;
      REQ_READ = 1'b0;
      REQ_REG = 5'h0;
      REQ_WDATA = 16'h0000;
      PACKET_DETECT = 1'b0;
      POWER_LEVEL = LVL;
      SLEEP_MODE = 1'b0;
      link_b.serial_port_clock = 1'b0;
      link_b.serial_latch_enable_n = 1'b1;
      link_b.host_data_out = 1'b0;
      link_b.host_data_oe_n = 1'b0;
      repeat (5) @(posedge CLOCK);
      #DLY RST = 1'b0;
      chk("reset fields", fld(IF_CONTROL_2_RESET), {8'h00, fa});
      @(posedge CLOCK);
      #DLY PACKET_DETECT = 1'b1;
      @(posedge CLOCK);
      #DLY PACKET_DETECT = 1'b0;
      repeat (MEAS_CYCLES + 10) @(posedge CLOCK);
      #DLY POWER_LEVEL = 7'h7F;
      repeat (MEAS_CYCLES) @(posedge CLOCK);
      chk("strength", {9'h0, LVL}, {9'h0, ss_code});
      for (int i = 0; i < 3; i++)
      begin
         access(1'b0, REG_IF_CONTROL_2, wv[i]);
         chk("fields", fld(wv[i]), {8'h00, fa});
      end
      for (int i = 0; i < 6; i++)
         access(1'b0, badr[i], 16'hFFFF);
      chk("ignored writes", fld(wv[2]), {8'h00, fa});
      access(1'b1, REG_SIGNAL_STRENGTH, 16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         access(1'b1, radr[i], 16'h0000);
         chk("read", rexp[i], q);
      end
      access(1'b0, REG_IF_CONTROL_2, 16'h0400);
      #DLY SLEEP_MODE = 1'b1;
      sleep_half(FAST_HALF_CYCLES);
      access(1'b0, REG_IF_CONTROL_2, 16'h0500);
      sleep_half(FAST_HALF_CYCLES);
      access(1'b0, REG_IF_CONTROL_2, 16'h0600);
      sleep_half(SLOW_HALF_CYCLES);
      access(1'b0, REG_IF_CONTROL_2, 16'h0700);
      quiet(2000);
      access(1'b0, REG_IF_CONTROL_2, 16'h0400);
      #DLY SLEEP_MODE = 1'b0;
      quiet(2000);
      raw_wr(3'h4, 16'h0B70, 1'b1);
      chk("other device", fld(IF_CONTROL_2_RESET), {8'h00, fb});
      raw_wr(DEV_ADDR, 16'h0B70, 1'b0);
      chk("no trailing pulse", fld(IF_CONTROL_2_RESET), {8'h00, fb});
      raw_wr(DEV_ADDR, 16'h0480, 1'b1);
      chk("trailing commit", fld(16'h0480), {8'h00, fb});
      complete_run();
   end
endmodule
